// ===== ebmf_top.sv
`default_nettype none

module ebmf_top #(
  parameter int ADDR_W = 10,
  parameter int DATA_W = 9
) (
  input wire logic clk_sys,
  input wire logic srst,
  // configuration
  input wire ebmf_pkg::ebmf_func_t cfg_function,
  input wire logic cfg_dual_port,
  input wire ebmf_pkg::ebmf_wmode_t cfg_write_mode_a,
  input wire ebmf_pkg::ebmf_wmode_t cfg_write_mode_b,
  input wire logic [ADDR_W-1:0] cfg_full_thresh,
  input wire logic [ADDR_W-1:0] cfg_afull_thresh,
  input wire logic [ADDR_W-1:0] cfg_aempty_thresh,
  output logic rbw_fallback,
  // random access ports
  input wire logic port_a_ce,
  input wire logic port_a_we,
  input wire logic [ADDR_W-1:0] port_a_addr,
  input wire logic [DATA_W-1:0] port_a_din,
  output logic [DATA_W-1:0] port_a_dout,
  input wire logic port_b_ce,
  input wire logic port_b_we,
  input wire logic [ADDR_W-1:0] port_b_addr,
  input wire logic [DATA_W-1:0] port_b_din,
  output logic [DATA_W-1:0] port_b_dout,
  // fifo write side
  input wire logic [DATA_W-1:0] fifo_wr_data,
  input wire logic write_clock_enable,
  input wire logic write_strobe,
  // fifo read side
  input wire logic read_clock_enable,
  input wire logic fetch_strobe,
  output logic [DATA_W-1:0] fifo_rd_data,
  // fifo control and status
  input wire logic global_fifo_reset,
  input wire logic fetch_pointer_rewind,
  output logic full_flag,
  output logic almost_full,
  output logic almost_empty_flag,
  output logic empty_flag,
  output logic [ADDR_W-1:0] fifo_level,
  output logic write_refused,
  output logic read_refused
);
  import ebmf_pkg::*;

  localparam bit RBW_OK = ebmf_rbw_width_ok(DATA_W);
  localparam logic [ADDR_W-1:0] THR_MIN = ADDR_W'(EBMF_THR_MIN);
  localparam logic [ADDR_W-1:0] PTR_RST = ADDR_W'(EBMF_PTR_RST);
  localparam logic [ADDR_W-1:0] EMPTY_LVL = ADDR_W'(EBMF_EMPTY_LEVEL);

  // ----------------------------------------------------------------
  // mode decode
  // ----------------------------------------------------------------
  logic is_fifo;
  logic is_ram;
  logic fifo_clear;
  ebmf_wmode_t mode_a_eff;
  ebmf_wmode_t mode_b_eff;

  assign is_fifo = (cfg_function == EBMF_FN_FIFO);
  assign is_ram = (cfg_function == EBMF_FN_RAM);
  assign fifo_clear = srst || global_fifo_reset;

  // read-before-write falls back to normal on other widths
  always_comb begin
    mode_a_eff = cfg_write_mode_a;
    mode_b_eff = cfg_write_mode_b;
    if (!RBW_OK && (cfg_write_mode_a == EBMF_WM_RBW)) begin
      mode_a_eff = EBMF_WM_NORMAL;
    end
    if (!RBW_OK && (cfg_write_mode_b == EBMF_WM_RBW)) begin
      mode_b_eff = EBMF_WM_NORMAL;
    end
  end

  assign rbw_fallback = !RBW_OK && ((cfg_write_mode_a == EBMF_WM_RBW) ||
                                    (cfg_write_mode_b == EBMF_WM_RBW));

  // ----------------------------------------------------------------
  // thresholds
  // ----------------------------------------------------------------
  logic [ADDR_W-1:0] full_thr;
  logic [ADDR_W-1:0] afull_thr;
  logic [ADDR_W-1:0] aempty_thr;

  // zero is out of range, top of range is the field's own limit
  assign full_thr = (cfg_full_thresh < THR_MIN) ? THR_MIN
                                                : cfg_full_thresh;

  ebmf_thresh #(
    .AW(ADDR_W)
  ) u_afull_thr (
    .raw_thresh(cfg_afull_thresh),
    .full_thresh(full_thr),
    .eff_thresh(afull_thr)
  );

  ebmf_thresh #(
    .AW(ADDR_W)
  ) u_aempty_thr (
    .raw_thresh(cfg_aempty_thresh),
    .full_thresh(full_thr),
    .eff_thresh(aempty_thr)
  );

  // ----------------------------------------------------------------
  // fifo accept terms
  // ----------------------------------------------------------------
  logic full_reg;
  logic afull_reg;
  logic aempty_reg;
  logic empty_reg;
  logic wr_try;
  logic rd_try;
  logic wr_go;
  logic rd_go;

  assign wr_try = is_fifo && write_clock_enable && write_strobe;
  assign rd_try = is_fifo && read_clock_enable && fetch_strobe;
  assign wr_go = wr_try && !full_reg && !global_fifo_reset;
  assign rd_go = rd_try && !empty_reg && !global_fifo_reset &&
                 !fetch_pointer_rewind;

  // ----------------------------------------------------------------
  // pointers
  // ----------------------------------------------------------------
  logic [ADDR_W-1:0] wr_ptr_reg;
  logic [ADDR_W-1:0] wr_ptr_next;
  logic [ADDR_W-1:0] rd_ptr_reg;
  logic [ADDR_W-1:0] rd_ptr_next;

  assign wr_ptr_next = wr_ptr_reg + ADDR_W'(wr_go);

  always_comb begin
    rd_ptr_next = rd_ptr_reg;
    if (fetch_pointer_rewind) begin
      rd_ptr_next = PTR_RST;
    end else if (rd_go) begin
      rd_ptr_next = rd_ptr_reg + ADDR_W'(1'b1);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (fifo_clear || !is_fifo) begin
      wr_ptr_reg <= PTR_RST;
    end else begin
      wr_ptr_reg <= wr_ptr_next;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (fifo_clear || !is_fifo) begin
      rd_ptr_reg <= PTR_RST;
    end else begin
      rd_ptr_reg <= rd_ptr_next;
    end
  end

  // ----------------------------------------------------------------
  // fill level
  // ----------------------------------------------------------------
  logic [ADDR_W-1:0] count_reg;
  logic [ADDR_W-1:0] count_next;

  always_comb begin
    if (fetch_pointer_rewind) begin
      // everything written since the last clear is readable again
      count_next = wr_ptr_next;
    end else begin
      count_next = count_reg + ADDR_W'(wr_go) - ADDR_W'(rd_go);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (fifo_clear || !is_fifo) begin
      count_reg <= EMPTY_LVL;
    end else begin
      count_reg <= count_next;
    end
  end

  assign fifo_level = count_reg;

  // ----------------------------------------------------------------
  // write-side flags
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (fifo_clear || !is_fifo) begin
      full_reg <= EBMF_FULL_RST;
    end else begin
      full_reg <= (count_next >= full_thr);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (fifo_clear || !is_fifo) begin
      afull_reg <= EBMF_AFULL_RST;
    end else begin
      afull_reg <= (count_next >= afull_thr);
    end
  end

  // ----------------------------------------------------------------
  // read-side flags
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (fifo_clear || !is_fifo) begin
      aempty_reg <= EBMF_AEMPTY_RST;
    end else begin
      aempty_reg <= (count_next <= aempty_thr);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (fifo_clear || !is_fifo) begin
      empty_reg <= EBMF_EMPTY_RST;
    end else begin
      empty_reg <= (count_next == EMPTY_LVL);
    end
  end

  assign full_flag = full_reg;
  assign almost_full = afull_reg;
  assign almost_empty_flag = aempty_reg;
  assign empty_flag = empty_reg;

  // ----------------------------------------------------------------
  // refused accesses, one-cycle pulses
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (fifo_clear) begin
      write_refused <= EBMF_EVENT_RST;
    end else begin
      write_refused <= wr_try && full_reg;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (fifo_clear) begin
      read_refused <= EBMF_EVENT_RST;
    end else begin
      read_refused <= rd_try && empty_reg && !fetch_pointer_rewind;
    end
  end

  // ----------------------------------------------------------------
  // memory port steering
  // ----------------------------------------------------------------
  logic mem_a_ce;
  logic mem_a_we;
  logic [ADDR_W-1:0] mem_a_addr;
  logic [DATA_W-1:0] mem_a_din;
  ebmf_wmode_t mem_a_mode;
  logic mem_b_ce;
  logic mem_b_we;
  logic [ADDR_W-1:0] mem_b_addr;
  logic [DATA_W-1:0] mem_b_din;
  ebmf_wmode_t mem_b_mode;
  logic mem_b_rst;
  logic [DATA_W-1:0] mem_a_dout;
  logic [DATA_W-1:0] mem_b_dout;

  always_comb begin
    // random access: rom ignores writes, single port idles b
    mem_a_ce = port_a_ce;
    mem_a_we = port_a_we && is_ram;
    mem_a_addr = port_a_addr;
    mem_a_din = port_a_din;
    mem_a_mode = mode_a_eff;
    mem_b_ce = port_b_ce && cfg_dual_port;
    mem_b_we = port_b_we && is_ram;
    mem_b_addr = port_b_addr;
    mem_b_din = port_b_din;
    mem_b_mode = mode_b_eff;
    if (is_fifo) begin
      mem_a_ce = write_clock_enable;
      mem_a_we = wr_go;
      mem_a_addr = wr_ptr_reg;
      mem_a_din = fifo_wr_data;
      mem_b_ce = rd_go;
      mem_b_we = 1'b0;
      mem_b_addr = rd_ptr_reg;
      mem_b_din = '0;
      mem_b_mode = EBMF_WM_NORMAL;
    end
  end

  // read output latch also clears on either fifo reset
  assign mem_b_rst = srst || (is_fifo && (global_fifo_reset ||
                                          fetch_pointer_rewind));

  ebmf_dpram #(
    .AW(ADDR_W),
    .DW(DATA_W)
  ) u_mem (
    .clk_sys(clk_sys),
    .a_rst(srst),
    .a_ce(mem_a_ce),
    .a_we(mem_a_we),
    .a_addr(mem_a_addr),
    .a_din(mem_a_din),
    .a_mode(mem_a_mode),
    .a_dout(mem_a_dout),
    .b_rst(mem_b_rst),
    .b_ce(mem_b_ce),
    .b_we(mem_b_we),
    .b_addr(mem_b_addr),
    .b_din(mem_b_din),
    .b_mode(mem_b_mode),
    .b_dout(mem_b_dout)
  );

  assign port_a_dout = mem_a_dout;
  assign port_b_dout = mem_b_dout;
  assign fifo_rd_data = mem_b_dout;

endmodule : ebmf_top

`default_nettype wire

// ===== ebmf_pkg.sv
// Function
// - normal mode: output changes only on reads
// - write-through mode: output shows written data
// - read-before-write: old contents, widths 9/18/36 only
// - single or dual port with every mode
// - block runs as RAM, ROM or FIFO
// - FIFO pointers and flags in dedicated logic
// - write port samples data, enable, strobe
// - separate read port: data-out, enable, strobe
// - four flags: full, almost full/empty, empty
// - full and almost full registered write side
// - empty and almost empty registered read side
// - full threshold 1 to 2^N-1, empty zero
// - almost thresholds 1 to full minus one
// - global reset clears pointers and flags
// - rewind resets read pointer, keeps data
`default_nettype none

package ebmf_pkg;

  // ----------------------------------------------------------------
  // geometry
  // ----------------------------------------------------------------
  localparam int EBMF_ADDR_W = 10;
  localparam int EBMF_DATA_W = 9;

  // widths that offer read-before-write
  localparam int EBMF_RBW_W_A = 9;
  localparam int EBMF_RBW_W_B = 18;
  localparam int EBMF_RBW_W_C = 36;

  // ----------------------------------------------------------------
  // thresholds and reset values
  // ----------------------------------------------------------------
  localparam int EBMF_THR_MIN = 1;
  localparam int EBMF_EMPTY_LEVEL = 0;
  localparam int EBMF_PTR_RST = 0;
  localparam logic EBMF_FULL_RST = 1'b0;
  localparam logic EBMF_AFULL_RST = 1'b0;
  localparam logic EBMF_AEMPTY_RST = 1'b1;
  localparam logic EBMF_EMPTY_RST = 1'b1;
  localparam logic EBMF_EVENT_RST = 1'b0;

  // ----------------------------------------------------------------
  // modes
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    EBMF_FN_RAM = 2'h0,
    EBMF_FN_ROM = 2'h1,
    EBMF_FN_FIFO = 2'h3
  } ebmf_func_t;

  typedef enum logic [1:0] {
    EBMF_WM_NORMAL = 2'h0,
    EBMF_WM_THROUGH = 2'h1,
    EBMF_WM_RBW = 2'h3
  } ebmf_wmode_t;

  function automatic bit ebmf_rbw_width_ok(int width);
    return (width == EBMF_RBW_W_A) || (width == EBMF_RBW_W_B) ||
           (width == EBMF_RBW_W_C);
  endfunction : ebmf_rbw_width_ok

endpackage : ebmf_pkg

`default_nettype wire

// ===== ebmf_thresh.sv
`default_nettype none

module ebmf_thresh #(
  parameter int AW = 10
) (
  input wire logic [AW-1:0] raw_thresh,
  input wire logic [AW-1:0] full_thresh,
  output logic [AW-1:0] eff_thresh
);
  import ebmf_pkg::*;

  localparam logic [AW-1:0] THR_MIN = AW'(EBMF_THR_MIN);

  logic [AW-1:0] top_thresh;

  // ----------------------------------------------------------------
  // clamp into 1 .. full-1
  // ----------------------------------------------------------------
  always_comb begin
    top_thresh = (full_thresh > THR_MIN) ? (full_thresh - THR_MIN) : THR_MIN;
    if (raw_thresh < THR_MIN) begin
      eff_thresh = THR_MIN;
    end else if (raw_thresh > top_thresh) begin
      eff_thresh = top_thresh;
    end else begin
      eff_thresh = raw_thresh;
    end
  end

endmodule : ebmf_thresh

`default_nettype wire

// ===== ebmf_dpram.sv
`default_nettype none

module ebmf_dpram #(
  parameter int AW = 10,
  parameter int DW = 9
) (
  input wire logic clk_sys,
  input wire logic a_rst,
  input wire logic a_ce,
  input wire logic a_we,
  input wire logic [AW-1:0] a_addr,
  input wire logic [DW-1:0] a_din,
  input wire ebmf_pkg::ebmf_wmode_t a_mode,
  output logic [DW-1:0] a_dout,
  input wire logic b_rst,
  input wire logic b_ce,
  input wire logic b_we,
  input wire logic [AW-1:0] b_addr,
  input wire logic [DW-1:0] b_din,
  input wire ebmf_pkg::ebmf_wmode_t b_mode,
  output logic [DW-1:0] b_dout
);
  import ebmf_pkg::*;

  logic [DW-1:0] mem [0:(1<<AW)-1];

  // output latch value for one port access
  function automatic logic [DW-1:0] port_out(
    input ebmf_wmode_t mode,
    input logic wr,
    input logic [DW-1:0] din,
    input logic [DW-1:0] stored,
    input logic [DW-1:0] held
  );
    logic [DW-1:0] res;
    res = stored;
    if (wr) begin
      case (mode)
        EBMF_WM_NORMAL: res = held;
        EBMF_WM_THROUGH: res = din;
        EBMF_WM_RBW: res = stored;
        default: res = held;
      endcase
    end
    return res;
  endfunction : port_out

  // ----------------------------------------------------------------
  // array writes; port a wins a same-address collision
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (b_ce && b_we) begin
      mem[b_addr] <= b_din;
    end
    if (a_ce && a_we) begin
      mem[a_addr] <= a_din;
    end
  end

  // ----------------------------------------------------------------
  // output latches
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (a_rst) begin
      a_dout <= '0;
    end else if (a_ce) begin
      a_dout <= port_out(a_mode, a_we, a_din, mem[a_addr], a_dout);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (b_rst) begin
      b_dout <= '0;
    end else if (b_ce) begin
      b_dout <= port_out(b_mode, b_we, b_din, mem[b_addr], b_dout);
    end
  end

endmodule : ebmf_dpram

`default_nettype wire

// ===== ebmf_props.sv
`default_nettype none
module ebmf_props #(
  parameter int ADDR_W = 10,
  parameter int DATA_W = 9
) (
  input wire logic clk_sys,
  input wire logic srst,
  input wire ebmf_pkg::ebmf_func_t cfg_function,
  input wire ebmf_pkg::ebmf_wmode_t cfg_write_mode_a,
  input wire logic [ADDR_W-1:0] cfg_full_thresh,
  input wire logic [ADDR_W-1:0] cfg_aempty_thresh,
  input wire logic port_a_ce,
  input wire logic port_a_we,
  input wire logic [DATA_W-1:0] port_a_din,
  input wire logic [DATA_W-1:0] port_a_dout,
  input wire logic write_clock_enable,
  input wire logic write_strobe,
  input wire logic read_clock_enable,
  input wire logic fetch_strobe,
  input wire logic [DATA_W-1:0] fifo_rd_data,
  input wire logic global_fifo_reset,
  input wire logic fetch_pointer_rewind,
  input wire logic full_flag,
  input wire logic almost_empty_flag,
  input wire logic empty_flag,
  input wire logic [ADDR_W-1:0] fifo_level,
  input wire logic write_refused,
  input wire logic read_refused
);
  timeunit 1ns;
  timeprecision 100ps;
  import ebmf_pkg::*;
  logic fifo, wr_try, rd_try, wr_ok, rd_ok;
  logic [ADDR_W-1:0] ft, ae;
  assign fifo = cfg_function == EBMF_FN_FIFO;
  assign wr_try = fifo && write_clock_enable && write_strobe &&
                  !global_fifo_reset;
  assign rd_try = fifo && read_clock_enable && fetch_strobe &&
                  !global_fifo_reset && !fetch_pointer_rewind;
  assign wr_ok = wr_try && !full_flag;
  assign rd_ok = rd_try && !empty_flag;
  // zero full threshold acts as one; almost empty kept below full
  assign ft = (cfg_full_thresh == '0) ? ADDR_W'(1) : cfg_full_thresh;
  assign ae = (ft == ADDR_W'(1) || cfg_aempty_thresh == '0) ? ADDR_W'(1) :
              (cfg_aempty_thresh >= ft) ? ft - 1'b1 : cfg_aempty_thresh;
  // ----------
  // assertions
  // ----------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);
  sequence s_steady;
    fifo && $past(fifo) && $stable(cfg_full_thresh) &&
    $stable(cfg_aempty_thresh);
  endsequence
  sequence s_wr_only;
    wr_ok && !rd_ok && !fetch_pointer_rewind;
  endsequence
  sequence s_rd_only;
    rd_ok && !wr_ok;
  endsequence
  property p_full;
    s_steady |-> full_flag == (fifo_level >= ft);
  endproperty
  a_full: assert property (p_full)
    else $error("full flag off its level");
  property p_aempty;
    s_steady |-> almost_empty_flag == (fifo_level <= ae);
  endproperty
  a_aempty: assert property (p_aempty)
    else $error("almost empty flag off its level");
  property p_wr_cnt;
    s_wr_only |=> fifo_level == $past(fifo_level) + 1'b1;
  endproperty
  a_wr_cnt: assert property (p_wr_cnt)
    else $error("write did not raise level");
  property p_rd_cnt;
    s_rd_only |=> fifo_level == $past(fifo_level) - 1'b1;
  endproperty
  a_rd_cnt: assert property (p_rd_cnt)
    else $error("read did not lower level");
  property p_wr_ref;
    wr_try && full_flag ##1 !(wr_try && full_flag) |->
      write_refused ##1 !write_refused;
  endproperty
  a_wr_ref: assert property (p_wr_ref)
    else $error("write refusal pulse wrong");
  property p_rd_ref;
    rd_try && empty_flag |=> read_refused;
  endproperty
  a_rd_ref: assert property (p_rd_ref)
    else $error("read refusal missing");
  property p_clear;
    global_fifo_reset |=> fifo_level == '0 && empty_flag &&
      almost_empty_flag && !full_flag;
  endproperty
  a_clear: assert property (p_clear)
    else $error("clear left state behind");
  property p_rewind;
    fifo && fetch_pointer_rewind && !global_fifo_reset |=>
      fifo_rd_data == '0;
  endproperty
  a_rewind: assert property (p_rewind)
    else $error("rewind kept read output");
  property p_through;
    port_a_ce && port_a_we && cfg_function == EBMF_FN_RAM &&
      cfg_write_mode_a == EBMF_WM_THROUGH |=>
      port_a_dout == $past(port_a_din);
  endproperty
  a_through: assert property (p_through)
    else $error("write data not shown");
endmodule : ebmf_props

bind ebmf_top ebmf_props #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) ebmf_props_inst (
  .clk_sys, .srst, .cfg_function, .cfg_write_mode_a, .cfg_full_thresh,
  .cfg_aempty_thresh, .port_a_ce, .port_a_we, .port_a_din, .port_a_dout,
  .write_clock_enable, .write_strobe, .read_clock_enable, .fetch_strobe,
  .fifo_rd_data, .global_fifo_reset, .fetch_pointer_rewind, .full_flag,
  .almost_empty_flag, .empty_flag, .fifo_level, .write_refused,
  .read_refused
);
`default_nettype wire

// ===== ebmf_user.sv
`default_nettype none
module ebmf_user #(
  parameter int DATA_W = 9
) (
  input wire logic clk_sys,
  input wire logic quiet,
  input wire logic want_wr,
  input wire logic want_rd,
  input wire logic [DATA_W-1:0] wdata,
  output logic write_clock_enable,
  output logic write_strobe,
  output logic read_clock_enable,
  output logic fetch_strobe,
  output logic [DATA_W-1:0] fifo_wr_data
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [DATA_W-1:0] last_reg = '0;
  // ----------
  // user ports
  // ----------
  // all enables and strobes idle while a reset is pending
  assign write_clock_enable = !quiet;
  assign read_clock_enable = !quiet;
  assign write_strobe = want_wr && !quiet;
  assign fetch_strobe = want_rd && !quiet;
  // idle data bus shows the inverse of the last word
  assign fifo_wr_data = write_strobe ? wdata : ~last_reg;
  always @(posedge clk_sys) begin
    if (write_strobe) begin
      last_reg <= wdata;
    end
  end
endmodule : ebmf_user
`default_nettype wire

// ===== ebmf_tb_top.sv
`default_nettype none
module ebmf_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import ebmf_pkg::*;
  localparam int AW = 4;
  localparam int DW = 9;
  logic clk_sys = 1'b0;
  logic srst = 1'b1;
  logic quiet = 1'b1;
  logic cfg_dual_port = 1'b1;
  ebmf_func_t cfg_function = EBMF_FN_FIFO;
  ebmf_wmode_t cfg_write_mode_a = EBMF_WM_NORMAL;
  logic [AW-1:0] cfg_full_thresh = 4'h6;
  logic [AW-1:0] cfg_afull_thresh = 4'h4;
  logic [AW-1:0] cfg_aempty_thresh = 4'h2;
  logic port_a_ce = 1'b0;
  logic port_a_we = 1'b0;
  logic [AW-1:0] port_a_addr = 4'h0;
  logic [DW-1:0] port_a_din = 9'h000;
  logic port_b_ce = 1'b0;
  logic [AW-1:0] port_b_addr = 4'h0;
  logic want_wr = 1'b0;
  logic want_rd = 1'b0;
  logic [DW-1:0] wdata = 9'h000;
  logic global_fifo_reset = 1'b0;
  logic fetch_pointer_rewind = 1'b0;
  logic rbw_fallback, write_clock_enable, write_strobe, read_clock_enable;
  logic fetch_strobe, full_flag, almost_full, almost_empty_flag, empty_flag;
  logic write_refused, read_refused;
  logic [DW-1:0] port_a_dout, port_b_dout, fifo_rd_data, fifo_wr_data;
  logic [AW-1:0] fifo_level;
  logic [3:0] flags;
  logic [DW-1:0] q[$];
  logic [DW-1:0] hist[$];
  int fails = 0;
  int num_checks = 0;
  assign flags = {full_flag, almost_full, almost_empty_flag, empty_flag};

  ebmf_top #(.ADDR_W(AW), .DATA_W(DW)) ebmf_top_inst (
    .clk_sys, .srst, .cfg_function, .cfg_dual_port,
    .cfg_write_mode_a, .cfg_write_mode_b(EBMF_WM_NORMAL), .cfg_full_thresh,
    .cfg_afull_thresh, .cfg_aempty_thresh, .rbw_fallback, .port_a_ce,
    .port_a_we, .port_a_addr, .port_a_din, .port_a_dout, .port_b_ce,
    .port_b_we(1'b0), .port_b_addr, .port_b_din(9'h000), .port_b_dout,
    .fifo_wr_data, .write_clock_enable, .write_strobe, .read_clock_enable,
    .fetch_strobe, .fifo_rd_data, .global_fifo_reset, .fetch_pointer_rewind,
    .full_flag, .almost_full, .almost_empty_flag, .empty_flag, .fifo_level,
    .write_refused, .read_refused
  );
  ebmf_user #(.DATA_W(DW)) ebmf_user_inst (
    .clk_sys, .quiet, .want_wr, .want_rd, .wdata, .write_clock_enable,
    .write_strobe, .read_clock_enable, .fetch_strobe, .fifo_wr_data
  );

  initial begin
    forever #2.5 clk_sys = ~clk_sys;
  end

  // -------
  // helpers
  // -------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic final_report;
    if (fails == 0 && num_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : final_report

  function automatic logic [3:0] flags_exp(input int lvl);
    int f;
    int af;
    int ae;
    f = (cfg_full_thresh == 0) ? 1 : int'(cfg_full_thresh);
    af = (cfg_afull_thresh == 0) ? 1 : int'(cfg_afull_thresh);
    ae = (cfg_aempty_thresh == 0) ? 1 : int'(cfg_aempty_thresh);
    if (f > 1 && af >= f) af = f - 1;
    if (f > 1 && ae >= f) ae = f - 1;
    if (f == 1) af = 1;
    if (f == 1) ae = 1;
    return {lvl >= f, lvl >= af, lvl <= ae, lvl == 0};
  endfunction : flags_exp

  // one fifo cycle: outcome judged from flags seen before the edge
  task automatic cyc(input logic w, input logic r, input logic [DW-1:0] d);
    logic wa;
    logic ra;
    wa = w && !full_flag;
    ra = r && !empty_flag;
    want_wr = w;
    want_rd = r;
    wdata = d;
    @(negedge clk_sys);
    chk(write_refused, w && !wa);
    chk(read_refused, r && !ra);
    if (ra) chk(fifo_rd_data, q.pop_front());
    if (wa) q.push_back(d);
    if (wa) hist.push_back(d);
    chk(fifo_level, q.size());
    chk(flags, flags_exp(q.size()));
  endtask : cyc

  // full clear or read pointer rewind, strobes idled around it
  task automatic pulse(input logic rew);
    want_wr = 1'b0;
    want_rd = 1'b0;
    quiet = 1'b1;
    @(negedge clk_sys);
    global_fifo_reset = !rew;
    fetch_pointer_rewind = rew;
    @(negedge clk_sys);
    global_fifo_reset = 1'b0;
    fetch_pointer_rewind = 1'b0;
    @(negedge clk_sys);
    quiet = 1'b0;
    if (!rew) hist.delete();
    q = hist;
    chk(fifo_level, q.size());
    chk(fifo_rd_data, 0);
    chk(flags, flags_exp(q.size()));
  endtask : pulse

  task automatic ram(input logic b, input logic we, input logic [AW-1:0] a,
                     input logic [DW-1:0] d);
    port_a_ce = !b;
    port_a_we = we;
    port_a_addr = a;
    port_a_din = d;
    port_b_ce = b;
    port_b_addr = a;
    @(negedge clk_sys);
  endtask : ram

  // ---------
  // scenarios
  // ---------
  initial begin
    int seed;
    logic [11:0] thr_tab [3];
    ebmf_wmode_t mtab [3];
    logic [AW-1:0] a;
    logic [DW-1:0] d0, d1, e, x;
    seed = 32'h94C8;
    thr_tab = '{12'h642, 12'h033, 12'hFE1};
    mtab = '{EBMF_WM_NORMAL, EBMF_WM_THROUGH, EBMF_WM_RBW};
    repeat (4) @(negedge clk_sys);
    srst = 1'b0;
    @(negedge clk_sys);
    chk(fifo_level, 0);
    chk(flags, 4'h3);
    for (int s = 0; s < 3; s++) begin
      pulse(1'b0);
      {cfg_full_thresh, cfg_afull_thresh, cfg_aempty_thresh} = thr_tab[s];
      // fill past full, then drain past empty
      for (int i = 0; i < 120; i++) begin
        cyc((($random(seed) & 3) != 0) == (i < 60),
            (($random(seed) & 3) != 0) != (i < 60), DW'($random(seed)));
      end
    end
    pulse(1'b0);
    cyc(1'b1, 1'b0, 9'h1A5);
    cyc(1'b1, 1'b0, 9'h05A);
    cyc(1'b1, 1'b1, 9'h133);
    cyc(1'b0, 1'b1, 9'h000);
    pulse(1'b1);
    repeat (4) cyc(1'b0, 1'b1, 9'h000);
    cfg_function = EBMF_FN_RAM;
    chk(rbw_fallback, 0);
    for (int m = 0; m < 3; m++) begin
      cfg_write_mode_a = mtab[m];
      a = AW'($random(seed));
      d0 = DW'($random(seed));
      e = ~d0;
      d1 = d0 ^ 9'h0F0;
      x = (m == 0) ? e : (m == 1) ? d1 : d0;
      ram(1'b0, 1'b1, a, d0);
      ram(1'b0, 1'b1, a + 1'b1, e);
      ram(1'b0, 1'b0, a + 1'b1, d1);
      chk(port_a_dout, e);
      ram(1'b0, 1'b1, a, d1);
      chk(port_a_dout, x);
      ram(1'b1, 1'b0, a, d1);
      chk(port_b_dout, d1);
    end
    cfg_function = EBMF_FN_ROM;
    ram(1'b0, 1'b1, a, e);
    ram(1'b0, 1'b0, a, e);
    chk(port_a_dout, d1);
    // single port: b access ignored, its output frozen
    cfg_dual_port = 1'b0;
    ram(1'b1, 1'b0, a + 1'b1, e);
    chk(port_b_dout, d1);
    final_report();
  end

  // run needs about 410 cycles; cut off at 2000
  initial begin
    #10000;
    fails++;
    final_report();
  end
endmodule : ebmf_tb_top
`default_nettype wire
